/* hw/parity_calc.sv */
// parity generator over a masked nine-bit character
// assumes the caller masks off bits beyond the character size
`timescale 1ns/1ps
module parity_calc (
   input  wire logic [8:0] i_data,
   input  wire logic       i_odd,
   output logic            o_parity
);
   // even: one when the count of ones is odd; odd: inverted
   assign o_parity = (^i_data) ^ i_odd;
endmodule : parity_calc

/* hw/uart_aux.sv */
// auxiliary serial-receiver logic: parity, frame-start wake, address filter,
// events and the three interrupt vectors
// assumes the shift logic delivers one-cycle frame strobes on this clock
//
// Summary of operation
// - even parity bit is one when data ones count is odd
// - odd parity bit is one when data ones count is even
// - with checking on, mismatch of received parity sets the parity error flag
// - constrained auto-baud mode checks parity only on protected identifier
// - identifier parity: p0 and inverted p1 equations both must hold
// - in standby, rx falling edge requests oscillator; peripheral clock too only with rx start enable
// - false start bit with no other wake source returns to sleep
// - frame-start detect only in asynchronous mode, enabled by control two
// - start bit detected in standby sets rx start flag
// - detect on, both rx interrupts off: only oscillator runs
// - rx start enable wakes at start; else rx complete enable wakes at end
// - start and complete flags share the receive vector, own enables
// - address mode frame type from first stop bit or ninth bit
// - frame type one is address, zero is data
// - address mode drops every data frame and accepts only address frames
// - sync and spi host modes emit the synchronised serial clock level as event
// - infrared event input is synchronised and its rising edge taken as a one-cycle pulse
// - receive vector: unread data, start detect, or auto-baud error
// - tx empty condition while transmit buffer can accept data
// - tx done once shifter empty and buffer empty
// - request while flag and enable set, until flag cleared
// - each source enabled by its own bit in control one
// - parity error cleared on good parity or when checking is off
// - rx complete flag follows unread data in receive buffer
`timescale 1ns/1ps
module uart_aux (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic [7:0]      o_rdata,
   input  wire logic       i_rxd_pin,
   input  wire logic       i_standby,
   input  wire logic       i_other_wake,
   input  wire logic       i_frame_valid,
   input  wire logic [8:0] i_frame_data,
   input  wire logic       i_frame_parity,
   input  wire logic       i_frame_stop1,
   input  wire logic       i_frame_is_pid,
   input  wire logic       i_start_false,
   input  wire logic       i_rx_unread,
   input  wire logic       i_tx_buf_empty,
   input  wire logic       i_tx_shift_idle,
   input  wire logic       i_sync_error,
   input  wire logic       i_autobaud_error,
   input  wire logic       i_serial_clock,
   input  wire logic       i_infrared_event,
   output logic            o_frame_accept,
   output logic            o_osc_request,
   output logic            o_clk_request,
   output logic            o_serial_clock_output,
   output logic            o_infrared_pulse,
   output logic            o_receive_vector,
   output logic            o_tx_empty_vector,
   output logic            o_tx_done_vector
);
   logic [7:0] control_one_r;
   logic [7:0] control_two_r;
   logic [7:0] control_three_r;
   logic       event_enable_r;
   logic       parity_error_flag_r;
   logic       rx_start_flag_r;
   logic       sync_field_error_flag_r;
   logic       rxd_s1_r, rxd_s2_r, rxd_s3_r;
   logic       sclk_s1_r, sclk_s2_r, sclk_s3_r;
   logic       ir_s1_r, ir_s2_r, ir_s3_r;
   logic       calc_parity;
   logic [8:0] masked_data;

   typedef enum logic [1:0] {
      WAKE_IDLE = 2'b00,
      WAKE_OSC  = 2'b01,
      WAKE_ALL  = 2'b10
   } wake_type;
   wake_type wake_r;

   wire logic [1:0] parity_select       = control_three_r[uart_aux_pkg::C3_PAR_LO +: 2];
   wire logic [1:0] receive_mode_select = control_two_r[uart_aux_pkg::C2_MODE_LO +: 2];
   wire logic [1:0] comm_mode           = control_three_r[uart_aux_pkg::C3_CMODE_LO +: 2];
   wire logic [2:0] char_size           = control_three_r[uart_aux_pkg::C3_SIZE_LO +: 3];
   wire logic constrained_autobaud_mode = (receive_mode_select == uart_aux_pkg::RXM_LIN);
   wire logic frame_start_wake_enable   = control_two_r[uart_aux_pkg::C2_SFD];
   wire logic address_filter_mode       = control_two_r[uart_aux_pkg::C2_ADDRF];
   wire logic rx_complete_int_enable    = control_one_r[uart_aux_pkg::C1_RX_COMPLETE_INT_ENABLE];
   wire logic rx_start_int_enable       = control_one_r[uart_aux_pkg::C1_RX_START_INT_ENABLE];
   wire logic autobaud_error_int_enable = control_one_r[uart_aux_pkg::C1_AUTOBAUD_ERROR_INT_ENABLE];
   wire logic tx_empty_int_enable       = control_one_r[uart_aux_pkg::C1_TX_EMPTY_INT_ENABLE];
   wire logic tx_done_int_enable        = control_one_r[uart_aux_pkg::C1_TX_DONE_INT_ENABLE];
   wire logic parity_on   = parity_select[1];
   wire logic nine_bit    = (char_size == uart_aux_pkg::SIZE_9L) ||
                            (char_size == uart_aux_pkg::SIZE_9H);
   wire logic is_async    = (comm_mode == uart_aux_pkg::CMODE_ASYNC);
   wire logic sfd_active  = frame_start_wake_enable && is_async;
   wire logic rxd_fall    = rxd_s3_r && !rxd_s2_r;

   // data bits covered by parity: nine bits only in nine-bit mode
   assign masked_data = nine_bit ? i_frame_data : {1'b0, i_frame_data[7:0]};

   parity_calc u_parity (
      .i_data   (masked_data),
      .i_odd    (parity_select == uart_aux_pkg::PAR_ODD),
      .o_parity (calc_parity)
   );

   // identifier parity check over the six id bits and two parity bits
   function automatic logic pid_bad(input logic [7:0] f);
      logic p0;
      logic p1;
      p0 = f[0] ^ f[1] ^ f[2] ^ f[4];
      p1 = ~(f[1] ^ f[3] ^ f[4] ^ f[5]);
      pid_bad = (f[6] != p0) || (f[7] != p1);
   endfunction : pid_bad

   // pin and event synchronisers; only stage two onward is read
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         {rxd_s1_r, rxd_s2_r, rxd_s3_r}    <= 3'h7;
         {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= 3'h0;
         {ir_s1_r, ir_s2_r, ir_s3_r}       <= 3'h0;
      end else begin
         {rxd_s1_r, rxd_s2_r, rxd_s3_r}    <= {i_rxd_pin, rxd_s1_r, rxd_s2_r};
         {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= {i_serial_clock, sclk_s1_r, sclk_s2_r};
         {ir_s1_r, ir_s2_r, ir_s3_r}       <= {i_infrared_event, ir_s1_r, ir_s2_r};
      end
   end

   // control registers written by software
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         control_one_r   <= uart_aux_pkg::RESET_BYTE;
         control_two_r   <= uart_aux_pkg::RESET_BYTE;
         control_three_r <= uart_aux_pkg::RESET_BYTE;
         event_enable_r  <= 1'b0;
      end else if (i_wr) begin
         case (i_addr)
            uart_aux_pkg::ADDR_CTRL_ONE: control_one_r   <= i_wdata;
            uart_aux_pkg::ADDR_CTRL_TWO: control_two_r   <= i_wdata;
            uart_aux_pkg::ADDR_CTRL_THR: control_three_r <= i_wdata;
            uart_aux_pkg::ADDR_EVENT:    event_enable_r  <= i_wdata[0];
            default: ;
         endcase
      end
   end

   // parity error flag updated on every valid frame
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         parity_error_flag_r <= 1'b0;
      end else if (i_frame_valid) begin
         if (constrained_autobaud_mode) begin
            parity_error_flag_r <= i_frame_is_pid && pid_bad(i_frame_data[7:0]);
         end else if (parity_on) begin
            parity_error_flag_r <= (calc_parity != i_frame_parity);
         end else begin
            parity_error_flag_r <= 1'b0;
         end
      end
   end

   // address filter: drop every data frame, accept only address frames
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_frame_accept <= 1'b0;
      end else begin
         o_frame_accept <= 1'b0;
         if (!address_filter_mode) begin
            o_frame_accept <= i_frame_valid;
         end else if (i_frame_valid) begin
            // frame type from ninth bit or first stop bit
            o_frame_accept <= nine_bit ? i_frame_data[8] : i_frame_stop1;
         end
      end
   end

   // sticky flags; a new event beats a software clear in the same cycle
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rx_start_flag_r         <= 1'b0;
         sync_field_error_flag_r <= 1'b0;
      end else begin
         if (sfd_active && i_standby && rxd_fall) begin
            rx_start_flag_r <= 1'b1;
         end else if (i_wr && i_addr == uart_aux_pkg::ADDR_STATUS &&
                      i_wdata[uart_aux_pkg::ST_RXS]) begin
            rx_start_flag_r <= 1'b0;
         end
         if (i_sync_error || i_autobaud_error) begin
            sync_field_error_flag_r <= 1'b1;
         end else if (i_wr && i_addr == uart_aux_pkg::ADDR_STATUS &&
                      i_wdata[uart_aux_pkg::ST_ISF]) begin
            sync_field_error_flag_r <= 1'b0;
         end
      end
   end

   // standby wake policy: oscillator always, all clocks by enable choice
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         wake_r <= WAKE_IDLE;
      end else begin
         case (wake_r)
            WAKE_IDLE: begin
               if (sfd_active && i_standby && rxd_fall) begin
                  wake_r <= rx_start_int_enable ? WAKE_ALL : WAKE_OSC;
               end
            end
            WAKE_OSC: begin
               if (i_start_false && !i_other_wake) begin
                  wake_r <= WAKE_IDLE;
               end else if (rx_complete_int_enable && i_rx_unread) begin
                  wake_r <= WAKE_ALL;
               end else if (!i_standby) begin
                  wake_r <= WAKE_IDLE;
               end
            end
            WAKE_ALL: begin
               if (!i_standby) begin
                  wake_r <= WAKE_IDLE;
               end else if (i_start_false && !i_other_wake) begin
                  wake_r <= WAKE_IDLE;
               end
            end
            default: wake_r <= WAKE_IDLE;
         endcase
      end
   end

   // clock requests; with both rx enables off only the oscillator runs
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_osc_request <= 1'b0;
         o_clk_request <= 1'b0;
      end else begin
         o_osc_request <= (wake_r != WAKE_IDLE);
         o_clk_request <= (wake_r == WAKE_ALL);
      end
   end

   // event generator and event user; serial clock level and infrared rising edge after sync
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_serial_clock_output <= 1'b0;
         o_infrared_pulse      <= 1'b0;
      end else begin
         // level follows the serial clock, so high lasts as long as the input is high
         o_serial_clock_output <= ((comm_mode == uart_aux_pkg::CMODE_SYNC) ||
                                   (comm_mode == uart_aux_pkg::CMODE_SPI)) && sclk_s2_r;
         o_infrared_pulse      <= event_enable_r && ir_s2_r && !ir_s3_r;
      end
   end

   // interrupt vectors: shared receive line, separate enables
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_receive_vector  <= 1'b0;
         o_tx_empty_vector <= 1'b0;
         o_tx_done_vector  <= 1'b0;
      end else begin
         o_receive_vector  <= (rx_complete_int_enable && i_rx_unread) ||
                              (rx_start_int_enable && rx_start_flag_r) ||
                              (autobaud_error_int_enable && sync_field_error_flag_r);
         o_tx_empty_vector <= tx_empty_int_enable && i_tx_buf_empty;
         o_tx_done_vector  <= tx_done_int_enable && i_tx_buf_empty &&
                              i_tx_shift_idle;
      end
   end

   // read mux; unmapped indices read as zero
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_rdata <= uart_aux_pkg::RESET_BYTE;
      end else if (i_rd) begin
         case (i_addr)
            uart_aux_pkg::ADDR_STATUS: o_rdata <= {i_rx_unread,
                                       i_tx_buf_empty && i_tx_shift_idle,
                                       i_tx_buf_empty, rx_start_flag_r,
                                       sync_field_error_flag_r, 3'h0};
            uart_aux_pkg::ADDR_RX_HIGH: o_rdata <= {i_rx_unread, 5'h00,
                                       parity_error_flag_r, i_frame_data[8]};
            uart_aux_pkg::ADDR_CTRL_ONE: o_rdata <= control_one_r;
            uart_aux_pkg::ADDR_CTRL_TWO: o_rdata <= control_two_r;
            uart_aux_pkg::ADDR_CTRL_THR: o_rdata <= control_three_r;
            uart_aux_pkg::ADDR_EVENT:    o_rdata <= {7'h00, event_enable_r};
            default: o_rdata <= uart_aux_pkg::RESET_BYTE;
         endcase
      end else begin
         o_rdata <= uart_aux_pkg::RESET_BYTE;
      end
   end

   // checks
   property p_start_flag;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (sfd_active && i_standby && rxd_fall) |=> rx_start_flag_r;
   endproperty
   a_start_flag: assert property (p_start_flag) else $error("start flag not set");
   property p_parity_off;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_frame_valid && !parity_on && !constrained_autobaud_mode) |=> !parity_error_flag_r;
   endproperty
   a_parity_off: assert property (p_parity_off) else $error("parity flag set while off");
   property p_parity_chk;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_frame_valid && parity_on && !constrained_autobaud_mode &&
       (calc_parity != i_frame_parity)) |=> parity_error_flag_r;
   endproperty
   a_parity_chk: assert property (p_parity_chk) else $error("parity error missed");
   property p_lin_data;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_frame_valid && constrained_autobaud_mode && !i_frame_is_pid) |=> !parity_error_flag_r;
   endproperty
   a_lin_data: assert property (p_lin_data) else $error("lin data parity checked");
   property p_filter;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_frame_valid && address_filter_mode && nine_bit && !i_frame_data[8]) |=> !o_frame_accept;
   endproperty
   a_filter: assert property (p_filter) else $error("data frame passed filter");
   property p_false_start;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (wake_r != WAKE_IDLE && i_start_false && !i_other_wake) |=> ##1 !o_osc_request;
   endproperty
   a_false_start: assert property (p_false_start) else $error("no return to sleep");
   property p_osc_only;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (wake_r == WAKE_OSC && !rx_complete_int_enable) |=> ##1 !o_clk_request;
   endproperty
   a_osc_only: assert property (p_osc_only) else $error("clocks woke with enables off");
   property p_tx_done;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_tx_done_vector |-> $past(i_tx_buf_empty && i_tx_shift_idle);
   endproperty
   a_tx_done: assert property (p_tx_done) else $error("tx done early");
   property p_rx_vec;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (rx_start_int_enable && rx_start_flag_r) |=> o_receive_vector;
   endproperty
   a_rx_vec: assert property (p_rx_vec) else $error("receive vector missing");
   c_wake_all: cover property (@(posedge i_core_clk) wake_r == WAKE_ALL);
   c_parity_error_flag: cover property (@(posedge i_core_clk) parity_error_flag_r);
   c_accept: cover property (@(posedge i_core_clk) address_filter_mode && o_frame_accept);
endmodule : uart_aux

/* shared/uart_aux_pkg.sv */
// constants shared by the auxiliary serial-receiver logic
// assumes a single core clock and a plain strobe register port
package uart_aux_pkg;
   // register indices
   localparam logic [3:0] ADDR_STATUS   = 4'h4;
   localparam logic [3:0] ADDR_CTRL_ONE = 4'h5;
   localparam logic [3:0] ADDR_CTRL_TWO = 4'h6;
   localparam logic [3:0] ADDR_CTRL_THR = 4'h7;
   localparam logic [3:0] ADDR_RX_HIGH  = 4'h1;
   localparam logic [3:0] ADDR_EVENT    = 4'hC;
   // status bits
   localparam int ST_RXC = 7;
   localparam int ST_TXC = 6;
   localparam int ST_DRE = 5;
   localparam int ST_RXS = 4;
   localparam int ST_ISF = 3;
   // control one bits
   localparam int C1_RX_COMPLETE_INT_ENABLE = 7;
   localparam int C1_TX_DONE_INT_ENABLE = 6;
   localparam int C1_TX_EMPTY_INT_ENABLE = 5;
   localparam int C1_RX_START_INT_ENABLE = 4;
   localparam int C1_AUTOBAUD_ERROR_INT_ENABLE = 2;
   // control two bits
   localparam int C2_SFD    = 4;
   localparam int C2_MODE_LO = 1;
   localparam int C2_ADDRF  = 0;
   // control three fields
   localparam int C3_CMODE_LO = 6;
   localparam int C3_PAR_LO   = 4;
   localparam int C3_SIZE_LO  = 0;
   // rx high bits
   localparam int RH_PARITY_ERROR_FLAG = 1;
   localparam int RH_D8   = 0;
   // encodings
   localparam logic [1:0] PAR_EVEN   = 2'h2;
   localparam logic [1:0] PAR_ODD    = 2'h3;
   localparam logic [1:0] RXM_LIN    = 2'h3;
   localparam logic [1:0] CMODE_ASYNC = 2'h0;
   localparam logic [1:0] CMODE_SYNC  = 2'h1;
   localparam logic [1:0] CMODE_SPI   = 2'h3;
   localparam logic [2:0] SIZE_9L    = 3'h6;
   localparam logic [2:0] SIZE_9H    = 3'h7;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] DRE_RESET  = 8'h20;
endpackage : uart_aux_pkg

/* tb/far_uart_model.sv */
// far-end sender model: presents finished frames and drives the rx pin
// assumes one-cycle frame strobes on the core clock; the line idles high
`timescale 1ns/1ps
module far_uart_model (
   input  wire logic       i_core_clk,
   input  wire logic       i_accept,
   output logic            o_rxd,
   output logic            o_valid,
   output logic [8:0]      o_data,
   output logic            o_parity,
   output logic            o_stop1,
   output logic            o_is_pid,
   output logic            o_start_false
);
   // line held high by its pull-up until a frame starts
   initial begin
      o_rxd = 1'b1;
      o_valid = 1'b0;
      o_data = 9'h000;
      o_parity = 1'b0;
      o_stop1 = 1'b1;
      o_is_pid = 1'b0;
      o_start_false = 1'b0;
   end
   // one frame; data, stop and identifier fields are inverted afterwards so stale values never match
   task automatic send(input logic [8:0] d, input logic odd, input logic st,
                       input logic pid, input logic bad, output logic acc);
      @(posedge i_core_clk);
      o_valid <= 1'b1;
      o_data <= d;
      o_parity <= (odd ? ~^d : ^d) ^ bad;
      o_stop1 <= st; // first stop bit carries the frame type
      o_is_pid <= pid;
      @(posedge i_core_clk);
      o_valid <= 1'b0;
      o_data <= ~d;
      o_stop1 <= ~st;
      o_is_pid <= ~pid;
      #1;
      acc = i_accept;
   endtask : send
   // protected identifier with both parity bits, optionally spoiled
   task automatic send_pid(input logic [5:0] id, input logic bad, output logic acc);
      logic p0;
      logic p1;
      p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
      p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
      send({1'b0, p1 ^ bad, p0, id}, 1'b0, 1'b1, 1'b1, 1'b0, acc);
   endtask : send_pid
   // start edge on the pin
   task automatic fall();
      @(posedge i_core_clk);
      o_rxd <= 1'b0;
   endtask : fall
   // start bit turns out false: line back high, receiver told
   task automatic abort();
      @(posedge i_core_clk);
      o_rxd <= 1'b1;
      o_start_false <= 1'b1;
      @(posedge i_core_clk);
      o_start_false <= 1'b0;
   endtask : abort
endmodule : far_uart_model

/* tb/tb_top.sv */
// self-checking bench for the auxiliary receiver logic
// assumes the far model supplies frames; bench owns registers and levels
`timescale 1ns/1ps
module tb_top;
   logic       clk, rst_n, wr_s, rd_s, stb, owk, unread, tbe, tsi, serr, aerr, sclk, ir;
   logic       rxd, fv, fpar, fst, fpid, ffalse, acc, osc, ckr, sco, irp, rv, tev, tdv, sco_q;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, q, sc_cnt, ir_cnt, s0;
   logic [8:0] fdat;
   logic [7:0] pat [5] = '{8'h00, 8'h01, 8'hA5, 8'hFF, 8'h80};
   logic [1:0] cm [3];
   int         fail_count, tests_run;

   uart_aux i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_rxd_pin(rxd), .i_standby(stb),
      .i_other_wake(owk), .i_frame_valid(fv), .i_frame_data(fdat), .i_frame_parity(fpar),
      .i_frame_stop1(fst), .i_frame_is_pid(fpid), .i_start_false(ffalse),
      .i_rx_unread(unread), .i_tx_buf_empty(tbe), .i_tx_shift_idle(tsi),
      .i_sync_error(serr), .i_autobaud_error(aerr), .i_serial_clock(sclk),
      .i_infrared_event(ir), .o_frame_accept(acc), .o_osc_request(osc),
      .o_clk_request(ckr), .o_serial_clock_output(sco), .o_infrared_pulse(irp),
      .o_receive_vector(rv), .o_tx_empty_vector(tev), .o_tx_done_vector(tdv));
   far_uart_model i_far (.i_core_clk(clk), .i_accept(acc), .o_rxd(rxd), .o_valid(fv),
      .o_data(fdat), .o_parity(fpar), .o_stop1(fst), .o_is_pid(fpid),
      .o_start_false(ffalse));

   // 100 MHz core clock
   always #5 clk = ~clk;
   // edge and pulse counters for the two event paths
   always @(posedge clk) begin
      if (!rst_n) begin
         {sco_q, sc_cnt, ir_cnt} <= '0;
      end else begin
         sco_q <= sco;
         if (sco && !sco_q) sc_cnt <= sc_cnt + 8'h01;
         if (irp) ir_cnt <= ir_cnt + 8'h01;
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      d = rdata;
   endtask : rd
   // single ended verdict for both normal end and watchdog
   task automatic print_verdict();
      if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   // watchdog: the whole sequence needs well under 5000 cycles
   initial begin
      #100000;
      fail_count++;
      print_verdict();
   end

   initial begin
      {clk, rst_n, wr_s, rd_s, stb, owk, unread, tsi, serr, aerr, sclk, ir} = '0;
      {addr, wdata} = '0;
      tbe = 1'b1;
      fail_count = 0;
      tests_run = 0;
      cm = '{uart_aux_pkg::CMODE_ASYNC, uart_aux_pkg::CMODE_SYNC, uart_aux_pkg::CMODE_SPI};
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      // reset values, unmapped place, tx empty level in status
      rd(uart_aux_pkg::ADDR_CTRL_ONE, q); chk(q, uart_aux_pkg::RESET_BYTE);
      rd(uart_aux_pkg::ADDR_STATUS, q); chk(q, uart_aux_pkg::DRE_RESET);
      wr(4'hF, 8'hFF);
      rd(4'hF, q); chk(q, 8'h00);
      // parity off, even, odd over a data table, good and spoiled
      for (int m = 0; m < 3; m++) for (int i = 0; i < 5; i++) for (int b = 0; b < 2; b++) begin
         wr(uart_aux_pkg::ADDR_CTRL_THR, {2'h0, (m == 0) ? 2'h0 : {1'b1, m == 2}, 4'h3});
         i_far.send({1'b0, pat[i]}, m == 2, 1'b1, 1'b0, b[0], q[0]);
         rd(uart_aux_pkg::ADDR_RX_HIGH, q); chk(q[1], (m != 0) && b[0]);
      end
      // constrained auto-baud: only the identifier is checked
      wr(uart_aux_pkg::ADDR_CTRL_TWO, {5'h00, uart_aux_pkg::RXM_LIN, 1'b0});
      for (int i = 0; i < 4; i++) begin
         i_far.send_pid(pat[i][5:0] ^ 6'h2A, i[0], q[0]);
         rd(uart_aux_pkg::ADDR_RX_HIGH, q); chk(q[1], i[0]);
      end
      i_far.send(9'h0A5, 1'b0, 1'b1, 1'b0, 1'b1, q[0]);
      rd(uart_aux_pkg::ADDR_RX_HIGH, q); chk(q[1], 1'b0);
      // address filter: stop bit for 8-bit chars, ninth bit for nine
      wr(uart_aux_pkg::ADDR_CTRL_THR, 8'h03);
      wr(uart_aux_pkg::ADDR_CTRL_TWO, 8'h01);
      i_far.send(9'h011, 1'b0, 1'b0, 1'b0, 1'b0, q[0]); chk(q[0], 1'b0);
      i_far.send(9'h011, 1'b0, 1'b1, 1'b0, 1'b0, q[0]); chk(q[0], 1'b1);
      wr(uart_aux_pkg::ADDR_CTRL_THR, {5'h00, uart_aux_pkg::SIZE_9L});
      i_far.send(9'h011, 1'b0, 1'b1, 1'b0, 1'b0, q[0]); chk(q[0], 1'b0);
      wr(uart_aux_pkg::ADDR_CTRL_THR, {5'h00, uart_aux_pkg::SIZE_9H});
      i_far.send(9'h111, 1'b0, 1'b0, 1'b0, 1'b0, q[0]); chk(q[0], 1'b1);
      wr(uart_aux_pkg::ADDR_CTRL_TWO, 8'h00);
      i_far.send(9'h011, 1'b0, 1'b0, 1'b0, 1'b0, q[0]); chk(q[0], 1'b1);
      // receive vector sources and flag clearing
      wr(uart_aux_pkg::ADDR_CTRL_ONE, 8'h80);
      @(posedge clk) unread <= 1'b1;
      step(3); chk(rv, 1'b1);
      rd(uart_aux_pkg::ADDR_RX_HIGH, q); chk(q[7], 1'b1);
      @(posedge clk) unread <= 1'b0;
      step(3); chk(rv, 1'b0);
      wr(uart_aux_pkg::ADDR_CTRL_ONE, 8'h04);
      @(posedge clk) serr <= 1'b1;
      @(posedge clk) serr <= 1'b0;
      step(8); chk(rv, 1'b1);
      wr(uart_aux_pkg::ADDR_STATUS, 8'h08);
      step(3); chk(rv, 1'b0);
      @(posedge clk) aerr <= 1'b1;
      @(posedge clk) aerr <= 1'b0;
      step(3); chk(rv, 1'b1);
      wr(uart_aux_pkg::ADDR_STATUS, 8'h08);
      // transmit vectors follow their live conditions
      wr(uart_aux_pkg::ADDR_CTRL_ONE, 8'h60);
      @(posedge clk) tsi <= 1'b1;
      step(3); chk({tev, tdv}, 2'h3);
      @(posedge clk) tbe <= 1'b0;
      step(3); chk({tev, tdv}, 2'h0);
      // frame-start wake with the start interrupt enabled, then a false start
      wr(uart_aux_pkg::ADDR_CTRL_THR, 8'h03);
      wr(uart_aux_pkg::ADDR_CTRL_TWO, 8'h10);
      wr(uart_aux_pkg::ADDR_CTRL_ONE, 8'h10);
      @(posedge clk) stb <= 1'b1;
      i_far.fall(); step(8); chk({osc, ckr, rv}, 3'h7);
      rd(uart_aux_pkg::ADDR_STATUS, q); chk(q[4], 1'b1);
      i_far.abort(); step(6); chk(osc, 1'b0);
      wr(uart_aux_pkg::ADDR_STATUS, 8'h10);
      step(2); chk(rv, 1'b0);
      // only the complete interrupt: clocks wait for unread data
      wr(uart_aux_pkg::ADDR_CTRL_ONE, 8'h80);
      i_far.fall(); step(8); chk(ckr, 1'b0);
      @(posedge clk) unread <= 1'b1;
      step(4); chk(ckr, 1'b1);
      @(posedge clk) unread <= 1'b0;
      i_far.abort(); @(posedge clk) stb <= 1'b0;
      // both disabled: oscillator only; another wake source keeps it up
      wr(uart_aux_pkg::ADDR_CTRL_ONE, 8'h00);
      @(posedge clk) stb <= 1'b1;
      i_far.fall(); step(8); chk({osc, ckr}, 2'h2);
      @(posedge clk) owk <= 1'b1;
      i_far.abort(); step(6); chk(osc, 1'b1);
      @(posedge clk) {owk, stb} <= 2'h0;
      // synchronous mode: no frame-start wake
      wr(uart_aux_pkg::ADDR_CTRL_THR, 8'h40);
      @(posedge clk) stb <= 1'b1;
      i_far.fall(); step(8); chk(osc, 1'b0);
      i_far.abort(); @(posedge clk) stb <= 1'b0;
      // serial clock event per mode: four input periods each
      for (int m = 0; m < 3; m++) begin
         wr(uart_aux_pkg::ADDR_CTRL_THR, {cm[m], 6'h00});
         s0 = sc_cnt;
         for (int k = 0; k < 8; k++) begin
            repeat (2) @(posedge clk);
            sclk <= ~sclk;
         end
         step(8); chk(sc_cnt - s0, (m == 0) ? 8'h00 : 8'h04);
      end
      // infrared event input, disabled then enabled
      for (int e = 0; e < 2; e++) begin
         wr(uart_aux_pkg::ADDR_EVENT, {7'h00, e[0]});
         s0 = ir_cnt;
         @(posedge clk) ir <= 1'b1;
         repeat (3) @(posedge clk);
         ir <= 1'b0;
         step(8); chk(ir_cnt - s0, {7'h00, e[0]});
      end
      print_verdict();
   end
endmodule : tb_top
